// File: bdfs_supervisor.sv
// Fault supervisor, enable watchdog and sleep control for a bridge driver.
`timescale 1ns/1ps
`include "bdfs_consts.svh"
module bdfs_supervisor #(
  parameter int SLEEP_CYC = `BDFS_CYC(`BDFS_SLEEP_NS),
  parameter int WAKE_CYC = `BDFS_CYC(`BDFS_WAKE_NS),
  parameter int RST_CYC = `BDFS_CYC(`BDFS_RST_NS),
  parameter int ETO_CYC = `BDFS_CYC(`BDFS_ETO_NS)
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  input wire logic enable_in,
  input wire logic sleep_wake_pin_n_in,
  input wire logic frame_strobe_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  input wire logic overtemp_in,
  input wire logic temp_warning_in,
  input wire logic logic_pin_overvolt_in,
  input wire logic supply_overvolt_in,
  input wire logic supply_undervolt_in,
  input wire logic regulator_overvolt_in,
  input wire logic regulator_undervolt_in,
  input wire logic bridge_fault_in,
  input wire logic charge_pump_ok_in,
  input wire logic logic_supply_ok_in,
  input wire logic [3:0] gate_cmd_in,
  output logic [3:0] gate_drive_out,
  output logic gate_permit_out,
  output logic fault_summary_flag_out,
  output logic [5:0] sense_gain_out,
  output logic [11:0] sense_offset_mv_out
);

  // ----------------------------------------
  // Decoders.
  // ----------------------------------------

  // Sense amplifier gain from its 3-bit select.
  function automatic logic [5:0] gain_dec(input logic [2:0] code);
    case (code)
      3'h7: gain_dec = 6'h32;
      default: gain_dec = 6'h0a + 6'({3'h0, code}) * 6'h05;
    endcase
  endfunction : gain_dec

  // Sense amplifier output offset in millivolts from its 4-bit select.
  function automatic logic [11:0] ofs_dec(input logic [3:0] code);
    case (code)
      4'h0, 4'h1: ofs_dec = 12'h000;
      4'h2, 4'h3: ofs_dec = 12'h064;
      default:
      begin
        if (code < 4'h8)
          ofs_dec = 12'({8'h00, code} - 12'h2) * 12'h064;
        else
          ofs_dec = 12'h2ee + 12'({8'h00, code} - 12'h8) * 12'h0fa;
      end
    endcase
  endfunction : ofs_dec

  // ----------------------------------------
  // State.
  // ----------------------------------------

  bdfs_pkg::bdfs_state_t st; // Present state.
  bdfs_pkg::bdfs_state_t next_st; // Next state.

  // Fixed-width copies of the timing parameters for comparisons.
  localparam logic [15:0] DOZE_C = 16'(`BDFS_CYC(`BDFS_DOZE_NS));
  localparam logic [15:0] SLEEP_C = 16'(SLEEP_CYC);
  localparam logic [15:0] WAKE_C = 16'(WAKE_CYC);
  localparam logic [15:0] RST_C = 16'(RST_CYC);
  localparam logic [23:0] ETO_C = 24'(ETO_CYC);

  // Outputs all come straight from state flip-flops.
  assign rd_data_out = st.rdata;
  assign serial_data_out = st.shf[15];
  assign gate_drive_out = st.gate;
  assign gate_permit_out = st.permit;
  assign fault_summary_flag_out = st.ff;
  assign sense_gain_out = st.gain;
  assign sense_offset_mv_out = st.ofs;

  // ----------------------------------------
  // Next-state logic.
  // ----------------------------------------

  // All behaviour is computed here from the inputs and the registered copy of the state.
  always_comb
  begin
    logic [14:0] p;
    logic en, sck, str, slp_pin;
    logic str_fall, str_rise, sck_rise, frame_ok;
    logic clear_req, stat_clr, wake_clr, pulse_clr;
    logic ot_l, tw_l, vlo_l, vso_l, vsu_l, vro_l, vru_l, brg_l;
    logic en_path, perm;
    logic [15:0] stat_w;
    logic [14:0] pin_v; // Raw pin levels before the synchroniser.
    logic wd_expire; // Watchdog ran out this cycle.
    // Locals start at zero so that no path leaves a latch behind.
    p = '0;
    pin_v = '0;
    wd_expire = 1'b0;
    // Monitor levels are filled in below once the pins are synchronised.
    ot_l = 1'b0;
    tw_l = 1'b0;
    vlo_l = 1'b0;
    vso_l = 1'b0;
    vsu_l = 1'b0;
    vro_l = 1'b0;
    vru_l = 1'b0;
    brg_l = 1'b0;
    en = 1'b0;
    sck = 1'b0;
    str = 1'b0;
    slp_pin = 1'b0;
    str_fall = 1'b0;
    str_rise = 1'b0;
    sck_rise = 1'b0;
    frame_ok = 1'b0;
    clear_req = 1'b0;
    stat_clr = 1'b0;
    wake_clr = 1'b0;
    pulse_clr = 1'b0;
    en_path = 1'b0;
    perm = 1'b0;
    stat_w = '0;
    next_st = st;

    // Two-flop synchronisers; only the second stage is read below.
    // The raw pins are gathered once and fed to the first stage.
    pin_v = {logic_supply_ok_in, charge_pump_ok_in, bridge_fault_in,
             regulator_undervolt_in, regulator_overvolt_in,
             supply_undervolt_in, supply_overvolt_in,
             logic_pin_overvolt_in, temp_warning_in, overtemp_in,
             enable_in, sleep_wake_pin_n_in, frame_strobe_n_in,
             serial_clk_in, serial_data_in};
    next_st.s1 = pin_v;
    next_st.s2 = st.s1;
    p = st.s2;
    en = p[`BDFS_P_EN];
    sck = p[`BDFS_P_SCK];
    str = p[`BDFS_P_STR];
    slp_pin = p[`BDFS_P_SLP];
    next_st.en_d = en;
    next_st.sck_d = sck;
    next_st.str_d = str;
    next_st.slp_d = slp_pin;

    // Live monitor levels; masking removes the diagnostic and its action.
    ot_l = p[`BDFS_P_OT];
    tw_l = p[`BDFS_P_TW] & ~st.mask[`BDFS_M_TW];
    vlo_l = p[`BDFS_P_VLO] & ~st.mask[`BDFS_M_VLO];
    vso_l = p[`BDFS_P_VSO] & ~st.mask[`BDFS_D_VSO];
    vsu_l = p[`BDFS_P_VSU] & ~st.mask[`BDFS_D_VSU];
    vro_l = p[`BDFS_P_VRO] & ~st.mask[`BDFS_D_VRO];
    vru_l = p[`BDFS_P_VRU] & ~st.mask[`BDFS_D_VRU];
    brg_l = p[`BDFS_P_BRG] & ~st.mask[`BDFS_D_BRG];

    // Register writes from the local bus.
    clear_req = wr_in && (addr_in == `BDFS_A_CLR);
    if (wr_in && (addr_in == `BDFS_A_CTRL))
      next_st.ctrl = wdata_in[8:0];
    if (wr_in && (addr_in == `BDFS_A_MASK))
      next_st.mask = wdata_in[7:0];

    // Serial frame: status is loaded as the strobe falls, MSB first.
    stat_w = {st.ff, st.por, st.se, st.ot, st.tw, st.logic_pin_overvolt_flag,
              st.enable_timeout_flag, |st.diag, 8'h00};
    str_fall = st.str_d & ~str;
    str_rise = ~st.str_d & str;
    sck_rise = ~st.sck_d & sck & ~str;
    if (str_fall)
    begin
      next_st.shf = stat_w;
      next_st.bcnt = '0;
      next_st.par = 1'b0;
    end
    else if (sck_rise)
    begin
      // Count saturates one past a full frame so overruns are seen.
      next_st.shf = {st.shf[14:0], 1'b0};
      next_st.rx = {st.rx[14:0], p[`BDFS_P_SDI]};
      next_st.par = st.par ^ p[`BDFS_P_SDI];
      if (st.bcnt != `BDFS_FRAME_OVER)
        next_st.bcnt = st.bcnt + 5'h01;
    end
    // Exactly sixteen edges and odd parity make a good frame.
    frame_ok = (st.bcnt == `BDFS_FRAME_BITS) && st.par;
    // A write to the clear register or a good write frame resets the status bits.
    stat_clr = clear_req |
               (str_rise & frame_ok & st.rx[`BDFS_WR_BIT]);

    // Sleep pin: low time sets doze and sleep, its rise wakes or clears.
    if (!slp_pin)
    begin
      if (st.low_cnt != 16'hffff)
        next_st.low_cnt = st.low_cnt + 16'h0001;
      if (st.low_cnt >= SLEEP_C)
        next_st.slp = bdfs_pkg::BDFS_SLEEP;
      else if (st.low_cnt >= DOZE_C)
        next_st.slp = bdfs_pkg::BDFS_DOZE;
    end
    else
      next_st.low_cnt = '0;
    if (slp_pin && !st.slp_d)
    begin
      if (st.slp == bdfs_pkg::BDFS_DOZE || st.slp == bdfs_pkg::BDFS_SLEEP)
      begin
        wake_clr = 1'b1;
        next_st.slp = bdfs_pkg::BDFS_WAKE;
        next_st.wake_cnt = '0;
      end
      else if (st.low_cnt >= RST_C)
        pulse_clr = 1'b1;
    end

    // Wake settling: pump must report ready after the settle time.
    case (st.slp)
      bdfs_pkg::BDFS_WAKE:
      begin
        if (st.wake_cnt < WAKE_C)
          next_st.wake_cnt = st.wake_cnt + 16'h0001;
        else if (p[`BDFS_P_CP] && slp_pin)
          next_st.slp = bdfs_pkg::BDFS_AWAKE;
      end
      default:
      begin
        // Rest at zero so that every wake waits the full settle time.
        next_st.wake_cnt = '0;
      end
    endcase

    // Enable watchdog.
    if (!st.ctrl[`BDFS_C_EWD])
    begin
      next_st.wd_on = 1'b0;
      next_st.wd_cnt = '0;
    end
    else if (en ^ st.en_d)
    begin
      next_st.wd_on = 1'b1;
      next_st.wd_cnt = '0;
    end
    else if (st.wd_on && !st.mask[`BDFS_M_ETO])
    begin
      if (st.wd_cnt >= ETO_C - 24'h000001)
      begin
        next_st.wd_on = 1'b0;
        wd_expire = 1'b1;
      end
      else
        next_st.wd_cnt = st.wd_cnt + 24'h000001;
    end

    // Sticky flags; a set in the clearing cycle wins.
    next_st.por = st.por & ~stat_clr & ~wake_clr;
    next_st.se = (st.se & ~stat_clr & ~wake_clr) |
                 (str_rise & ~frame_ok);
    next_st.ot = (st.ot & ~stat_clr & ~wake_clr) | ot_l;
    next_st.tw = (st.tw & ~stat_clr & ~wake_clr) | tw_l;
    next_st.logic_pin_overvolt_flag = (st.logic_pin_overvolt_flag & ~stat_clr & ~wake_clr) | vlo_l;
    // Only a real expiry sets the flag; leaving watchdog mode does not.
    // A masked timeout never expires, so it never sets the flag either.
    next_st.enable_timeout_flag = (st.enable_timeout_flag & ~stat_clr & ~wake_clr) | wd_expire;
    // Diagnostic bits ignore the short pulse and serial writes.
    next_st.diag = (st.diag & {5{~clear_req & ~wake_clr}}) |
                   {brg_l, vru_l, vro_l, vsu_l, vso_l};
    next_st.brg_lat = (st.brg_lat & ~pulse_clr & ~wake_clr) |
                      brg_l;

    // Output permission and gated command.
    en_path = st.ctrl[`BDFS_C_EWD] ? st.wd_on : en;
    perm = en_path && p[`BDFS_P_DL] &&
           (st.slp == bdfs_pkg::BDFS_AWAKE) && !st.brg_lat &&
           !(st.ctrl[`BDFS_C_ESF] && (ot_l || vlo_l)) &&
           !vsu_l && !vru_l;
    next_st.permit = perm;
    next_st.gate = gate_cmd_in & {4{perm}};

    // Sense decode outputs.
    next_st.gain = gain_dec(st.ctrl[`BDFS_C_GAIN]);
    next_st.ofs = ofs_dec(st.ctrl[`BDFS_C_OFS]);

    // Read data stand for one cycle only, zero otherwise.
    next_st.rdata = '0;
    if (rd_in)
    begin
      case (addr_in)
        `BDFS_A_CTRL: next_st.rdata = {7'h00, st.ctrl};
        `BDFS_A_MASK: next_st.rdata = {8'h00, st.mask};
        `BDFS_A_STAT: next_st.rdata = stat_w;
        `BDFS_A_DIAG: next_st.rdata = {11'h000, st.diag};
        `BDFS_A_GAIN: next_st.rdata = {10'h000, st.gain};
        `BDFS_A_OFS: next_st.rdata = {4'h0, st.ofs};
        `BDFS_A_LIVE: next_st.rdata = {11'h000, st.brg_lat, st.wd_on,
                                       st.slp, st.permit};
        default: next_st.rdata = '0;
      endcase
    end

    // Logic supply loss holds everything but the synchronisers at power-on values.
    // The synchronisers keep running so that the supply can be seen to
    // return; everything else rests at its power-on value.
    if (!p[`BDFS_P_DL])
    begin
      next_st = '0;
      next_st.s1 = pin_v;
      next_st.s2 = st.s1;
      // Strobe and sleep pin history rests at the idle high level, so
      // no false edge is seen when the supply returns.
      next_st.str_d = 1'b1;
      next_st.slp_d = 1'b1;
      next_st.por = 1'b1;
    end

    // The summary flag has its own flip-flop so that the pin is glitch
    // free; it is the OR of the next flag values.
    next_st.ff = |{next_st.por, next_st.se, next_st.ot, next_st.tw,
                   next_st.logic_pin_overvolt_flag, next_st.enable_timeout_flag, |next_st.diag};
  end

  // ----------------------------------------
  // State register.
  // ----------------------------------------

  // Reset gives power-on values with the power-on flag already set.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st <= '0;
      st.por <= 1'b1;
      st.ff <= 1'b1;
      // Idle-high pins start from their idle level to avoid false edges.
      st.str_d <= 1'b1;
      st.slp_d <= 1'b1;
    end
    else
    begin
      // Everything, synchronisers included, moves on together.
      st <= next_st;
    end
  end

endmodule : bdfs_supervisor

// File: bdfs_consts.svh
// Constants for the bridge driver fault supervisor.
`ifndef BDFS_CONSTS_SVH
`define BDFS_CONSTS_SVH
// ----------------------------------------
// Register offsets (4-bit word index).
// ----------------------------------------
`define BDFS_A_CTRL 4'h0
`define BDFS_A_MASK 4'h1
`define BDFS_A_STAT 4'h2
`define BDFS_A_DIAG 4'h3
`define BDFS_A_CLR 4'h4
`define BDFS_A_GAIN 4'h5
`define BDFS_A_OFS 4'h6
`define BDFS_A_LIVE 4'h7
// ----------------------------------------
// Control fields.
// ----------------------------------------
`define BDFS_C_EWD 0
`define BDFS_C_ESF 1
`define BDFS_C_GAIN 4:2
`define BDFS_C_OFS 8:5
// ----------------------------------------
// Mask and diagnostic bit positions.
// ----------------------------------------
`define BDFS_D_VSO 0
`define BDFS_D_VSU 1
`define BDFS_D_VRO 2
`define BDFS_D_VRU 3
`define BDFS_D_BRG 4
`define BDFS_M_TW 5
`define BDFS_M_VLO 6
`define BDFS_M_ETO 7
// ----------------------------------------
// Synchronised pin positions.
// ----------------------------------------
`define BDFS_P_SDI 0
`define BDFS_P_SCK 1
`define BDFS_P_STR 2
`define BDFS_P_SLP 3
`define BDFS_P_EN 4
`define BDFS_P_OT 5
`define BDFS_P_TW 6
`define BDFS_P_VLO 7
`define BDFS_P_VSO 8
`define BDFS_P_VSU 9
`define BDFS_P_VRO 10
`define BDFS_P_VRU 11
`define BDFS_P_BRG 12
`define BDFS_P_CP 13
`define BDFS_P_DL 14
`define BDFS_PINS 15
// ----------------------------------------
// Serial frame and timing.
// ----------------------------------------
`define BDFS_FRAME_BITS 5'h10
`define BDFS_FRAME_OVER 5'h11
`define BDFS_WR_BIT 10
`define BDFS_CLK_MHZ 10
`define BDFS_CYC(ns) (((ns) * `BDFS_CLK_MHZ + 999) / 1000)
`define BDFS_DOZE_NS 200000
`define BDFS_SLEEP_NS 1000000
`define BDFS_WAKE_NS 3000000
`define BDFS_RST_NS 1000
`define BDFS_ETO_NS 20000000
`endif

// File: bdfs_pkg.sv
// Types shared by the bridge driver fault supervisor.
package bdfs_pkg;
  // Sleep control states.
  typedef enum logic [1:0] {BDFS_AWAKE, BDFS_DOZE, BDFS_SLEEP, BDFS_WAKE}
    bdfs_slp_t;

  // Whole state of the supervisor.
  typedef struct packed {
    logic [14:0] s1;
    logic [14:0] s2;
    logic sck_d;
    logic str_d;
    logic en_d;
    logic slp_d;
    logic [8:0] ctrl;
    logic [7:0] mask;
    logic por;
    logic se;
    logic ot;
    logic tw;
    logic logic_pin_overvolt_flag;
    logic enable_timeout_flag;
    logic ff;
    logic [4:0] diag;
    logic brg_lat;
    bdfs_slp_t slp;
    logic [15:0] low_cnt;
    logic [15:0] wake_cnt;
    logic wd_on;
    logic [23:0] wd_cnt;
    logic [15:0] shf;
    logic [15:0] rx;
    logic [4:0] bcnt;
    logic par;
    logic permit;
    logic [3:0] gate;
    logic [15:0] rdata;
    logic [5:0] gain;
    logic [11:0] ofs;
  } bdfs_state_t;
endpackage : bdfs_pkg

// File: bdfs_supervisor_properties.sv
// Port-level assertions for the bridge driver fault supervisor.
`timescale 1ns/1ps
module bdfs_supervisor_properties (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rd_data_out,
  input wire logic sleep_wake_pin_n_in,
  input wire logic logic_supply_ok_in,
  input wire logic [3:0] gate_cmd_in,
  input wire logic [3:0] gate_drive_out,
  input wire logic gate_permit_out,
  input wire logic fault_summary_flag_out,
  input wire logic [5:0] sense_gain_out,
  input wire logic [11:0] sense_offset_mv_out
);
  // Gain for each select code.
  localparam logic [5:0] GT [8] = '{6'h0a, 6'h0f, 6'h14, 6'h19, 6'h1e,
    6'h23, 6'h28, 6'h32};
  logic [11:0] low_cnt; // Cycles the sleep pin has stayed low.
  logic [11:0] o; // Short name for the offset output.
  logic [2:0] wcode; // Gain field of the write data.

  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  assign o = sense_offset_mv_out;
  assign wcode = wdata_in[4:2];

  // Saturating count, so a long sleep never wraps back below the bound.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      low_cnt <= 12'h0;
    else if (sleep_wake_pin_n_in)
      low_cnt <= 12'h0;
    else if (low_cnt != 12'hfff)
      low_cnt <= low_cnt + 12'h1;
  end

  property p_sub;
    (gate_drive_out & ~$past(gate_cmd_in)) == 4'h0;
  endproperty
  property p_perm;
    |gate_drive_out |-> gate_permit_out;
  endproperty
  property p_por;
    $past(rst_b_in) == 1'b0 |-> fault_summary_flag_out;
  endproperty
  property p_supply;
    !logic_supply_ok_in [*4] |-> gate_drive_out == 4'h0 && !gate_permit_out;
  endproperty
  property p_gain;
    $past(wr_in, 2) && $past(addr_in, 2) == 4'h0
      |-> sense_gain_out == GT[$past(wcode, 2)];
  endproperty
  property p_ofs;
    (o <= 12'h1f4 && o % 12'h64 == 12'h0) ||
      (o >= 12'h2ee && o <= 12'h9c4 && o % 12'hfa == 12'h0);
  endproperty
  property p_ff;
    $past(rd_in) && $past(addr_in) == 4'h2
      |-> rd_data_out[15] == |rd_data_out[14:8];
  endproperty
  property p_sleep;
    low_cnt > 12'h7e4 |-> !gate_permit_out;
  endproperty

  a_sub: assert property (p_sub)
    else $error("Gate output on without a command.");
  a_perm: assert property (p_perm)
    else $error("Gate output on without permission.");
  a_por: assert property (p_por)
    else $error("Summary flag low after power-on reset.");
  a_supply: assert property (p_supply)
    else $error("Outputs stay on with the logic supply lost.");
  a_gain: assert property (p_gain)
    else $error("Gain output does not follow the code.");
  a_ofs: assert property (p_ofs)
    else $error("Offset output is not a legal step.");
  a_ff: assert property (p_ff)
    else $error("Summary bit disagrees with the status bits.");
  a_sleep: assert property (p_sleep)
    else $error("Outputs stay on with the sleep pin held low.");

  c_gate: cover property (|gate_drive_out);
  c_ff: cover property ($past(rd_in) && rd_data_out[15]);
  c_sleep: cover property (low_cnt > 12'h7e4);
endmodule : bdfs_supervisor_properties

bind bdfs_supervisor bdfs_supervisor_properties i_bdfs_supervisor_properties (
  .ref_clk_in(ref_clk_in),
  .rst_b_in(rst_b_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rd_data_out(rd_data_out),
  .sleep_wake_pin_n_in(sleep_wake_pin_n_in),
  .logic_supply_ok_in(logic_supply_ok_in),
  .gate_cmd_in(gate_cmd_in),
  .gate_drive_out(gate_drive_out),
  .gate_permit_out(gate_permit_out),
  .fault_summary_flag_out(fault_summary_flag_out),
  .sense_gain_out(sense_gain_out),
  .sense_offset_mv_out(sense_offset_mv_out)
);

// File: bdfs_mcu_model.sv
// Behavioural controller that drives the serial link of the supervisor.
`timescale 1ns/1ps
module bdfs_mcu_model (
  input wire logic ref_clk_in,
  input wire logic serial_data_in,
  output logic frame_strobe_n_out,
  output logic serial_clk_out,
  output logic serial_data_out
);
  // Link idles with the strobe high and the serial clock still.
  initial
  begin
    frame_strobe_n_out = 1'b1;
    serial_clk_out = 1'b0;
    serial_data_out = 1'b0;
  end

  // Sends n clock edges of w, MSB first; hp sets the link speed.
  // Counts other than 16 are only sent when a test asks for them.
  task automatic frame(input int n, input logic [15:0] w, input int hp,
    output logic [15:0] got);
    @(posedge ref_clk_in);
    frame_strobe_n_out <= 1'b0;
    repeat (hp) @(posedge ref_clk_in);
    got[15] = serial_data_in;
    for (int k = 0; k < n; k++)
    begin
      serial_data_out <= (k < 16) ? w[15 - k] : 1'b0;
      repeat (hp) @(posedge ref_clk_in);
      serial_clk_out <= 1'b1;
      repeat (hp) @(posedge ref_clk_in);
      if (k < 15)
        got[14 - k] = serial_data_in;
      serial_clk_out <= 1'b0;
    end
    repeat (hp) @(posedge ref_clk_in);
    frame_strobe_n_out <= 1'b1;
    // A released data line must not keep its last value.
    serial_data_out <= ~serial_data_out;
    repeat (8) @(posedge ref_clk_in);
  endtask : frame
endmodule : bdfs_mcu_model

// File: bridge_driver_fault_supervisor_test.sv
// Self-checking testbench for the bridge driver fault supervisor.
`timescale 1ns/1ps
module bridge_driver_fault_supervisor_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en = 1'b1;
  logic slp_n = 1'b1;
  logic [3:0] cmd = 4'h0;
  logic [7:0] mon = 8'h0; // Monitor levels, overtemp in bit 0.
  logic cp_ok = 1'b1;
  logic dl_ok = 1'b1;
  logic strb_n, sck, sdi, sdo, permit, ff;
  logic [15:0] rdata, got;
  logic [3:0] gdrv;
  logic [5:0] gain;
  logic [11:0] ofs;
  logic [31:0] seed = 32'hd34c0748;
  int errors = 0;
  int check_count = 0;
  int gtab[$] = '{10, 15, 20, 25, 30, 35, 40, 50}; // Gain model.

  // Short counts keep the watchdog and wake steps brief.
  bdfs_supervisor #(.SLEEP_CYC(40), .WAKE_CYC(20), .RST_CYC(4),
    .ETO_CYC(50)) i_bdfs_supervisor (.ref_clk_in(clk), .rst_b_in(rst_b),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rdata), .enable_in(en), .sleep_wake_pin_n_in(slp_n),
    .frame_strobe_n_in(strb_n), .serial_clk_in(sck),
    .serial_data_in(sdi), .serial_data_out(sdo), .overtemp_in(mon[0]),
    .temp_warning_in(mon[1]), .logic_pin_overvolt_in(mon[2]),
    .supply_overvolt_in(mon[3]), .supply_undervolt_in(mon[4]),
    .regulator_overvolt_in(mon[5]), .regulator_undervolt_in(mon[6]),
    .bridge_fault_in(mon[7]), .charge_pump_ok_in(cp_ok),
    .logic_supply_ok_in(dl_ok), .gate_cmd_in(cmd),
    .gate_drive_out(gdrv), .gate_permit_out(permit),
    .fault_summary_flag_out(ff), .sense_gain_out(gain),
    .sense_offset_mv_out(ofs));

  bdfs_mcu_model i_bdfs_mcu_model (.ref_clk_in(clk),
    .serial_data_in(sdo), .frame_strobe_n_out(strb_n),
    .serial_clk_out(sck), .serial_data_out(sdi));

  // ----
  // Helpers.
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Status model: any set fault bit also raises the summary bit.
  function automatic logic [15:0] st(input logic [15:0] f);
    return (f != 16'h0) ? (f | 16'h8000) : 16'h0;
  endfunction : st

  function automatic int ofs_mv(input int c);
    if (c < 2)
      return 0;
    if (c < 4)
      return 100;
    if (c < 8)
      return (c - 2) * 100;
    return 750 + (c - 8) * 250;
  endfunction : ofs_mv

  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read", rdata, e);
  endtask : rd_reg

  // Status read; the summary output must agree with bit 15.
  task automatic rs(input logic [15:0] e);
    rd_reg(4'h2, e);
    chk("summary", 16'(ff), 16'(e[15]));
  endtask : rs

  // Gate path latency is sync plus one register, so five cycles is ample.
  task automatic gate(input logic [3:0] e);
    cyc(5);
    chk("gate", 16'(gdrv), 16'(e));
    if (e != 4'h0 || cmd != 4'h0)
      chk("permit", 16'(permit), 16'(e != 4'h0));
  endtask : gate

  // ----
  // Stimulus.
  // ----
  initial
    forever #50 clk = ~clk;

  // A hung step still ends in the closing report.
  initial
  begin
    cyc(60000);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    cyc(16);
    rst_b <= 1'b1;
    cyc(4);
    rs(st(16'h4000));
    wr_reg(4'h4, 16'h0);
    rs(16'h0);
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(4'h0, 16'(((i % 8) << 2) | (i << 5)));
      cyc(3);
      chk("gain", 16'(gain), 16'(gtab[i % 8]));
      chk("offset", 16'(ofs), 16'(ofs_mv(i)));
    end
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      cmd <= seed[3:0];
      gate(seed[3:0]);
    end
    en <= 1'b0;
    gate(4'h0);
    cmd <= 4'hf;
    en <= 1'b1;
    wr_reg(4'h1, 16'h00ff);
    mon <= 8'h11;
    gate(4'hf);
    wr_reg(4'h0, 16'h0002);
    gate(4'h0);
    mon <= 8'h00;
    gate(4'hf);
    rs(st(16'h1000));
    wr_reg(4'h4, 16'h0);
    wr_reg(4'h1, 16'h0);
    wr_reg(4'h0, 16'h0001);
    en <= 1'b0;
    gate(4'hf);
    repeat (4)
    begin
      cyc(20);
      en <= ~en;
    end
    gate(4'hf);
    cyc(55);
    gate(4'h0);
    rs(st(16'h0200));
    en <= ~en;
    gate(4'hf);
    rs(st(16'h0200));
    wr_reg(4'h0, 16'h0);
    en <= 1'b1;
    wr_reg(4'h4, 16'h0);
    mon <= 8'h06;
    cyc(5);
    mon <= 8'h00;
    i_bdfs_mcu_model.frame(15, 16'h0400, 5, got);
    chk("first bit", 16'(got[15]), 16'h1);
    rs(st(16'h2c00));
    i_bdfs_mcu_model.frame(16, 16'h0400, 9, got);
    chk("shifted", got, st(16'h2c00));
    rs(16'h0);
    i_bdfs_mcu_model.frame(17, 16'h0400, 5, got);
    rs(st(16'h2000));
    mon <= 8'h80;
    gate(4'h0);
    mon <= 8'h00;
    gate(4'h0);
    slp_n <= 1'b0;
    cyc(10);
    slp_n <= 1'b1;
    gate(4'hf);
    rs(st(16'h2100));
    rd_reg(4'h3, 16'h0010);
    slp_n <= 1'b0;
    cyc(2100);
    gate(4'h0);
    cp_ok <= 1'b0;
    slp_n <= 1'b1;
    cyc(60);
    gate(4'h0);
    cp_ok <= 1'b1;
    cyc(5);
    gate(4'hf);
    rs(16'h0);
    dl_ok <= 1'b0;
    gate(4'h0);
    dl_ok <= 1'b1;
    cyc(40);
    rs(st(16'h4000));
    tally_and_finish();
  end
endmodule : bridge_driver_fault_supervisor_test
